// ===== rtl/pfb_blank_chop.sv
// pfb_blank_chop.sv: leading-edge and state blanking of fault and current
// limit inputs, plus chopping of the channel output pair.
// assumes pwm outputs come from logic on CLK_IN; comparator pins are async.
`timescale 1ns/1ps
`default_nettype none
`include "pfb_params.svh"

module pfb_blank_chop
	import pfb_pkg::*;
(
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic [3:0]  ADDR_IN,
	input  wire logic [15:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [15:0] RDATA_OUT,
	input  wire logic        PWM_MODULE_ENABLE_IN,
	input  wire pfb_pair_t   CHANNEL_OUT_IN,
	input  wire logic [2:0]  OTHER_HIGH_IN,
	input  wire logic        CHOP_CLOCK_IN,
	input  wire pfb_prot_t   PROT_PIN_IN,
	output pfb_prot_t        PROT_OUT,
	output logic             BLANK_ACTIVE_OUT,
	output pfb_pair_t        CHANNEL_OUT
);
	logic [15:0]    leb_ctrl_r;
	logic [15:0]    leb_delay_r;
	logic [15:0]    aux_ctrl_r;
	logic [11:0]    cnt_r;
	logic [11:0]    cnt_nxt;
	pfb_leb_state_t state_r;
	pfb_leb_state_t state_nxt;
	pfb_pair_t      prev_r;
	pfb_prot_t      prot_sync;
	logic           trig;
	logic           state_src;
	logic           chop_src;
	logic           state_mask;
	logic           level_mask;
	logic           leb_mask;
	logic           any_mask;
	logic [11:0]    dly;

	// pick one of the three other channel highs; shared by blank and chop select
	function automatic logic pick_src(input logic [3:0] sel, input logic [2:0] hi, input logic dflt);
		logic r;
		r = dflt;
		case (sel)
			`PFB_SEL_CH1: r = hi[0];
			`PFB_SEL_CH2: r = hi[1];
			`PFB_SEL_CH3: r = hi[2];
			default:      r = dflt;
		endcase
		return r;
	endfunction

	// true only for the three channel codes; zero and reserved codes select nothing
	function automatic logic is_chan_sel(input logic [3:0] sel);
		return (sel == `PFB_SEL_CH1) || (sel == `PFB_SEL_CH2) || (sel == `PFB_SEL_CH3);
	endfunction

	// comparator pins are asynchronous, so synchronise first
	pfb_sync2 #(.W(2)) u_sync (
		.clk_in   (CLK_IN),
		.rst_n_in (RST_N_IN),
		.d_in     (PROT_PIN_IN),
		.q_out    (prot_sync)
	);

	// register writes; reserved bits are never stored
	// reset and masks
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			leb_ctrl_r  <= `PFB_RST_LEB_CTRL;
			leb_delay_r <= `PFB_RST_LEB_DELAY;
			aux_ctrl_r  <= `PFB_RST_AUX_CTRL;
		end else if (WR_IN) begin
			// changes in flight are the software's risk
			case (ADDR_IN)
				`PFB_OFS_LEB_CTRL:  leb_ctrl_r  <= WDATA_IN & `PFB_MSK_LEB_CTRL;
				`PFB_OFS_LEB_DELAY: leb_delay_r <= WDATA_IN & `PFB_MSK_LEB_DELAY;
				`PFB_OFS_AUX_CTRL:  aux_ctrl_r  <= WDATA_IN & `PFB_MSK_AUX_CTRL;
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe, zero otherwise
	// upper delay bits read as zero
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			RDATA_OUT <= `PFB_RD_ZERO;
		end else if (RD_IN) begin
			case (ADDR_IN)
				`PFB_OFS_LEB_CTRL:  RDATA_OUT <= leb_ctrl_r;
				`PFB_OFS_LEB_DELAY: RDATA_OUT <= leb_delay_r;
				`PFB_OFS_AUX_CTRL:  RDATA_OUT <= aux_ctrl_r;
				`PFB_OFS_STATUS:    RDATA_OUT <= {12'h000, PWM_MODULE_ENABLE_IN, state_r, any_mask, cnt_r != `PFB_CNT_ZERO};
				default:            RDATA_OUT <= `PFB_RD_ZERO;
			endcase
		end else begin
			RDATA_OUT <= `PFB_RD_ZERO;
		end
	end

	a_delay_read: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(RD_IN && ADDR_IN == `PFB_OFS_LEB_DELAY) |=> (RDATA_OUT & ~`PFB_MSK_LEB_DELAY) == `PFB_RD_ZERO)
		else $error("delay upper bits not zero");

	a_reset_zero: assert property (@(posedge CLK_IN)
		!RST_N_IN |=> (leb_ctrl_r == `PFB_RST_LEB_CTRL && leb_delay_r == `PFB_RST_LEB_DELAY
		               && aux_ctrl_r == `PFB_RST_AUX_CTRL && RDATA_OUT == `PFB_RD_ZERO))
		else $error("registers not cleared by reset");

	a_aux_unimpl: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(RD_IN && ADDR_IN == `PFB_OFS_AUX_CTRL) |=> (RDATA_OUT & ~`PFB_MSK_AUX_CTRL) == `PFB_RD_ZERO)
		else $error("aux unimplemented bits not zero");

	// previous output levels for edge detection
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			prev_r <= '0;
		end else begin
			prev_r <= CHANNEL_OUT_IN;
		end
	end

	assign trig = (leb_ctrl_r[`PFB_B_HIGH_RISE] &  CHANNEL_OUT_IN.high & ~prev_r.high)
	            | (leb_ctrl_r[`PFB_B_HIGH_FALL] & ~CHANNEL_OUT_IN.high &  prev_r.high)
	            | (leb_ctrl_r[`PFB_B_LOW_RISE]  &  CHANNEL_OUT_IN.low  & ~prev_r.low)
	            | (leb_ctrl_r[`PFB_B_LOW_FALL]  & ~CHANNEL_OUT_IN.low  &  prev_r.low);
	assign dly = leb_delay_r[11:0];

	a_rise_trig: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(leb_ctrl_r[`PFB_B_HIGH_RISE] && $rose(CHANNEL_OUT_IN.high) && dly != `PFB_CNT_ZERO)
		|=> state_r == PFB_BLANK)
		else $error("high rising edge did not start blanking");

	a_fall_trig: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(leb_ctrl_r[`PFB_B_LOW_FALL] && $fell(CHANNEL_OUT_IN.low) && dly != `PFB_CNT_ZERO)
		|=> state_r == PFB_BLANK)
		else $error("low falling edge did not start blanking");

	a_trig_off: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(state_r == PFB_IDLE && leb_ctrl_r[`PFB_B_HIGH_RISE:`PFB_B_LOW_FALL] == 4'h0)
		|=> state_r == PFB_IDLE)
		else $error("blanking started with all edges disabled");

	always_comb begin
		cnt_nxt   = cnt_r;
		state_nxt = state_r;
		case (state_r)
			PFB_IDLE: begin
				if (trig && dly != `PFB_CNT_ZERO) begin
					cnt_nxt   = dly;
					state_nxt = PFB_BLANK;
				end
			end
			PFB_BLANK: begin
				if (trig && dly != `PFB_CNT_ZERO) begin
					cnt_nxt = dly;
				end else if (cnt_r == `PFB_CNT_ONE || cnt_r == `PFB_CNT_ZERO) begin
					cnt_nxt   = `PFB_CNT_ZERO;
					state_nxt = PFB_IDLE;
				end else begin
					cnt_nxt = cnt_r - `PFB_CNT_ONE;
				end
			end
			default: begin
				cnt_nxt   = `PFB_CNT_ZERO;
				state_nxt = PFB_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			cnt_r   <= `PFB_CNT_ZERO;
			state_r <= PFB_IDLE;
		end else begin
			cnt_r   <= cnt_nxt;
			state_r <= state_nxt;
		end
	end

	a_leb_load: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(trig && dly != `PFB_CNT_ZERO) |=> (cnt_r == $past(dly) && state_r == PFB_BLANK))
		else $error("blank counter did not load delay");

	a_leb_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(state_r == PFB_IDLE && (!trig || dly == `PFB_CNT_ZERO)) |=> state_r == PFB_IDLE)
		else $error("blanking started without a valid trigger");

	a_leb_count: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(state_r == PFB_BLANK && !trig && cnt_r != `PFB_CNT_ONE && cnt_r != `PFB_CNT_ZERO)
		|=> cnt_r == $past(cnt_r) - `PFB_CNT_ONE)
		else $error("blank counter did not count down");

	a_leb_end: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(state_r == PFB_BLANK && !trig && cnt_r == `PFB_CNT_ONE) |=> state_r == PFB_IDLE)
		else $error("blanking did not end at zero");

	assign leb_mask = (state_r == PFB_BLANK);

	// state blank source, code 0 gives a low level
	assign state_src = pick_src(aux_ctrl_r[`PFB_F_BLANK_SRC_HI:`PFB_F_BLANK_SRC_LO], OTHER_HIGH_IN, 1'b0);

	// state blanking only through the two enables; zero and reserved codes blank nothing
	// otherwise blank-on-low would mask forever on the default low level
	assign state_mask = is_chan_sel(aux_ctrl_r[`PFB_F_BLANK_SRC_HI:`PFB_F_BLANK_SRC_LO])
	                  & ((leb_ctrl_r[`PFB_B_SRC_HIGH] & state_src)
	                  |  (leb_ctrl_r[`PFB_B_SRC_LOW] & ~state_src));

	a_src_high: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(is_chan_sel(aux_ctrl_r[`PFB_F_BLANK_SRC_HI:`PFB_F_BLANK_SRC_LO])
		 && leb_ctrl_r[`PFB_B_SRC_HIGH] && state_src) |-> any_mask)
		else $error("state blank high not masking");

	a_src_low: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(is_chan_sel(aux_ctrl_r[`PFB_F_BLANK_SRC_HI:`PFB_F_BLANK_SRC_LO])
		 && leb_ctrl_r[`PFB_B_SRC_LOW] && !state_src) |-> any_mask)
		else $error("state blank low not masking");

	a_blank_reserved: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		!is_chan_sel(aux_ctrl_r[`PFB_F_BLANK_SRC_HI:`PFB_F_BLANK_SRC_LO]) |-> !state_mask)
		else $error("state blank from unselected source");

	a_state_none: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(leb_ctrl_r[`PFB_B_SRC_HIGH:`PFB_B_SRC_LOW] == 2'b00) |-> !state_mask)
		else $error("state blank without enable");

	assign level_mask = (leb_ctrl_r[`PFB_B_HI_HIGH] &  CHANNEL_OUT_IN.high)
	                  | (leb_ctrl_r[`PFB_B_HI_LOW]  & ~CHANNEL_OUT_IN.high)
	                  | (leb_ctrl_r[`PFB_B_LO_HIGH] &  CHANNEL_OUT_IN.low)
	                  | (leb_ctrl_r[`PFB_B_LO_LOW]  & ~CHANNEL_OUT_IN.low);

	a_level_blank: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(leb_ctrl_r[`PFB_B_HI_HIGH] && CHANNEL_OUT_IN.high) |-> any_mask)
		else $error("high level blanking missing");

	a_lo_low: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(leb_ctrl_r[`PFB_B_LO_LOW] && !CHANNEL_OUT_IN.low) |-> any_mask)
		else $error("low level blanking missing");

	assign any_mask = leb_mask | state_mask | level_mask;

	// per-input masking, registered for clean outputs
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			PROT_OUT         <= '0;
			BLANK_ACTIVE_OUT <= 1'b0;
		end else begin
			PROT_OUT.fault   <= prot_sync.fault  & ~(leb_ctrl_r[`PFB_B_FAULT_EN]  & any_mask);
			PROT_OUT.curlim  <= prot_sync.curlim & ~(leb_ctrl_r[`PFB_B_CURLIM_EN] & any_mask);
			BLANK_ACTIVE_OUT <= any_mask;
		end
	end

	a_fault_mask: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(leb_ctrl_r[`PFB_B_FAULT_EN] && any_mask) |=> !PROT_OUT.fault)
		else $error("fault passed during blanking");

	a_fault_pass: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		!leb_ctrl_r[`PFB_B_FAULT_EN] |=> PROT_OUT.fault == $past(prot_sync.fault))
		else $error("fault masked while blank disabled");

	a_curlim_mask: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(leb_ctrl_r[`PFB_B_CURLIM_EN] && any_mask) |=> !PROT_OUT.curlim)
		else $error("current limit passed during blanking");

	a_curlim_pass: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(!leb_ctrl_r[`PFB_B_CURLIM_EN] || !any_mask) |=> PROT_OUT.curlim == $past(prot_sync.curlim))
		else $error("current limit wrongly masked");

	// chop source, code 0 is the internal chop clock
	assign chop_src = pick_src(aux_ctrl_r[`PFB_F_CHOP_SRC_HI:`PFB_F_CHOP_SRC_LO], OTHER_HIGH_IN, CHOP_CLOCK_IN);

	// chop gates each output only when its enable is set
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			CHANNEL_OUT <= '0;
		end else begin
			CHANNEL_OUT.high <= CHANNEL_OUT_IN.high & (~aux_ctrl_r[`PFB_B_CHOP_HIGH] | chop_src);
			CHANNEL_OUT.low  <= CHANNEL_OUT_IN.low  & (~aux_ctrl_r[`PFB_B_CHOP_LOW]  | chop_src);
		end
	end

	a_chop_high: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		!aux_ctrl_r[`PFB_B_CHOP_HIGH] |=> CHANNEL_OUT.high == $past(CHANNEL_OUT_IN.high))
		else $error("high output chopped while disabled");

	a_chop_low: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(aux_ctrl_r[`PFB_B_CHOP_LOW] && !chop_src) |=> !CHANNEL_OUT.low)
		else $error("low output not chopped");

	a_chop_clock: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(aux_ctrl_r[`PFB_F_CHOP_SRC_HI:`PFB_F_CHOP_SRC_LO] == `PFB_SEL_NONE && aux_ctrl_r[`PFB_B_CHOP_HIGH])
		|=> CHANNEL_OUT.high == ($past(CHANNEL_OUT_IN.high) && $past(CHOP_CLOCK_IN)))
		else $error("internal chop clock not applied");
endmodule
`default_nettype wire

// ===== rtl/pfb_params.svh
// pfb_params.svh: offsets, field positions, reset values and codes for the
// pwm fault blanking and chop block. definitions only, no logic.
`ifndef PFB_PARAMS_SVH
`define PFB_PARAMS_SVH

// register offsets on the plain register port
`define PFB_OFS_LEB_CTRL   4'h0
`define PFB_OFS_LEB_DELAY  4'h1
`define PFB_OFS_AUX_CTRL   4'h2
`define PFB_OFS_STATUS     4'h3

// reset values
`define PFB_RST_LEB_CTRL   16'h0000
`define PFB_RST_LEB_DELAY  16'h0000
`define PFB_RST_AUX_CTRL   16'h0000

// implemented-bit masks, everything else reads as zero
`define PFB_MSK_LEB_CTRL   16'hfc3f
`define PFB_MSK_LEB_DELAY  16'h0fff
`define PFB_MSK_AUX_CTRL   16'h0f3f

// leading edge blank control fields
`define PFB_B_HIGH_RISE    15
`define PFB_B_HIGH_FALL    14
`define PFB_B_LOW_RISE     13
`define PFB_B_LOW_FALL     12
`define PFB_B_FAULT_EN     11
`define PFB_B_CURLIM_EN    10
`define PFB_B_SRC_HIGH     5
`define PFB_B_SRC_LOW      4
`define PFB_B_HI_HIGH      3
`define PFB_B_HI_LOW       2
`define PFB_B_LO_HIGH      1
`define PFB_B_LO_LOW       0

// aux control fields
`define PFB_F_BLANK_SRC_HI 11
`define PFB_F_BLANK_SRC_LO 8
`define PFB_F_CHOP_SRC_HI  5
`define PFB_F_CHOP_SRC_LO  2
`define PFB_B_CHOP_HIGH    1
`define PFB_B_CHOP_LOW     0

// source select codes
`define PFB_SEL_NONE       4'h0
`define PFB_SEL_CH1        4'h1
`define PFB_SEL_CH2        4'h2
`define PFB_SEL_CH3        4'h3

`define PFB_CNT_ZERO       12'h000
`define PFB_CNT_ONE        12'h001
`define PFB_RD_ZERO        16'h0000

`endif

// ===== rtl/pfb_pkg.sv
// pfb_pkg.sv: types shared by the blanking and chop block.
// assumes pfb_params.svh is on the include path.
package pfb_pkg;

	// raw comparator inputs of one channel
	typedef struct packed {
		logic fault;
		logic curlim;
	} pfb_prot_t;

	// high/low output pair of one channel
	typedef struct packed {
		logic high;
		logic low;
	} pfb_pair_t;

	// blanking counter state
	typedef enum logic [0:0] {
		PFB_IDLE  = 1'b0,
		PFB_BLANK = 1'b1
	} pfb_leb_state_t;

endpackage

// ===== rtl/pfb_sync2.sv
// pfb_sync2.sv: two flip-flop synchroniser for a bundle of pin levels.
// assumes one clock domain, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pfb_sync2 #(
	parameter int W = 2
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_r <= '0;
			q_out  <= '0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== tb/pfb_prot_model.sv
// pfb_prot_model.sv: comparator pins seen by the blanking block.
// assumes the bench commands the fault and limit levels on its clock.
`timescale 1ns/1ps
`default_nettype none
module pfb_prot_model
	import pfb_pkg::*;
(
	input  wire logic      clk_in,
	input  wire pfb_prot_t cmd_in,
	output pfb_prot_t      pin_out
);
	// pins follow the command one edge late, like a slow comparator
	always_ff @(posedge clk_in) begin
		pin_out <= cmd_in;
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// tb.sv: bench for the blanking and chop block, register tasks and checks.
// assumes the comparator model follows the levels the bench commands.
`timescale 1ns/1ps
`default_nettype none
module tb import pfb_pkg::*;;
	logic        clk;
	logic        rst_n;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        en;
	pfb_pair_t   chin;
	logic [2:0]  oth;
	logic        chop;
	pfb_prot_t   cmd;
	pfb_prot_t   pin;
	pfb_prot_t   prot;
	pfb_pair_t   chout;
	logic        bact;
	int          error_cnt;
	int          cmp_count;
	int          cyc;
	logic [3:0]  ad [4] = '{4'h0, 4'h1, 4'h2, 4'h7};
	logic [15:0] mk [4] = '{16'hfc3f, 16'h0fff, 16'h0f3f, 16'h0000};

	pfb_blank_chop DUT (
		.CLK_IN(clk),
		.RST_N_IN(rst_n),
		.ADDR_IN(addr),
		.WDATA_IN(wdata),
		.WR_IN(wr),
		.RD_IN(rd),
		.RDATA_OUT(rdata),
		.PWM_MODULE_ENABLE_IN(en),
		.CHANNEL_OUT_IN(chin),
		.OTHER_HIGH_IN(oth),
		.CHOP_CLOCK_IN(chop),
		.PROT_PIN_IN(pin),
		.PROT_OUT(prot),
		.BLANK_ACTIVE_OUT(bact),
		.CHANNEL_OUT(chout)
	);

	pfb_prot_model u_prot (
		.clk_in(clk),
		.cmd_in(cmd),
		.pin_out(pin)
	);

	// free running clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// samples mid-cycle so registered outputs have settled; ch 0 prot, 1 chout, 2 blank flag
	task automatic chk_pair(input logic [1:0] e, input logic [1:0] ch);
		logic [1:0] g;
		@(negedge clk);
		if (ch == 2'd1) begin
			g = chout;
		end else if (ch == 2'd2) begin
			g = {1'b0, bact};
		end else begin
			g = prot;
		end
		@(posedge clk);
		chk_reg({14'h0000, g}, {14'h0000, e});
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		en <= 1'b0;
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		en <= 1'b1;
		@(posedge clk);
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] d;
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
		chk_reg(d, e);
	endtask

	task automatic done(input string s);
		$display("test %s finished, mismatches %0d", s, error_cnt);
	endtask

	initial begin
		logic [2:0] m3;
		int i;
		int j;
		int k;
		rst_n = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		en = 1'b0;
		chin = 2'b00;
		oth = 3'b000;
		chop = 1'b0;
		cmd = 2'b11;
		step(2);
		rst_n <= 1'b1;
		step(1);
		for (i = 0; i < 4; i++) begin
			rd_chk(ad[i], 16'h0000);
		end
		for (i = 0; i < 4; i++) begin
			wr_reg(ad[i], 16'hffff);
			rd_chk(ad[i], mk[i]);
			wr_reg(ad[i], 16'h0000);
		end
		done("registers");
		// chop source per code, selected level on, others inverted
		chin <= 2'b11;
		for (i = 0; i < 5; i++) begin
			wr_reg(4'h2, 16'(i << 2) | 16'h0003);
			m3 = (i > 0 && i < 4) ? 3'b001 << (i - 1) : 3'b000;
			for (j = 0; j < 2; j++) begin
				oth <= j ? m3 : ~m3;
				chop <= (m3 == 3'b000) ? j[0] : ~j[0];
				step(2);
				chk_pair({j[0], j[0]}, 1'b1);
			end
		end
		wr_reg(4'h2, 16'h0002);
		chop <= 1'b0;
		step(2);
		chk_pair(2'b01, 1'b1);
		wr_reg(4'h2, 16'h0000);
		done("chop");
		// own output level blanking, both inputs enabled
		for (i = 0; i < 4; i++) begin
			wr_reg(4'h0, 16'h0c00 | (16'h0001 << i));
			for (j = 0; j < 2; j++) begin
				chin <= {j[0], j[0]};
				step(4);
				chk_pair((i % 2) == j ? 2'b00 : 2'b11, 1'b0);
				chk_pair((i % 2) == j ? 2'b01 : 2'b00, 2'd2);
				rd_chk(4'h3, (i % 2) == j ? 16'h000a : 16'h0008);
			end
		end
		done("level blanking");
		// state blank source, k picks high, low or neither
		for (i = 0; i < 5; i++) begin
			wr_reg(4'h2, 16'(i << 8));
			m3 = (i > 0 && i < 4) ? 3'b001 << (i - 1) : 3'b000;
			for (k = 0; k < 3; k++) begin
				wr_reg(4'h0, 16'h0c00 | (k == 2 ? 16'h0000 : 16'h0010 << (1 - k)));
				for (j = 0; j < 2; j++) begin
					oth <= j ? m3 : ~m3;
					step(4);
					chk_pair((m3 != 0 && k < 2 && j == 1 - k) ? 2'b00 : 2'b11, 1'b0);
				end
			end
		end
		wr_reg(4'h2, 16'h0000);
		done("state blanking");
		// each edge trigger, fault or limit enabled alternately
		oth <= 3'b000;
		wr_reg(4'h1, 16'h0008);
		for (i = 0; i < 4; i++) begin
			chin <= i[0] ? 2'b11 : 2'b00;
			step(6);
			wr_reg(4'h0, (16'h8000 >> i) | (i[0] ? 16'h0400 : 16'h0800));
			step(5);
			chin <= i[0] ? 2'b00 : 2'b11;
			step(3);
			chk_pair(i[0] ? 2'b10 : 2'b01, 1'b0);
			rd_chk(4'h3, 16'h000f);
			step(10);
			chk_pair(2'b11, 1'b0);
			chin <= i[0] ? 2'b11 : 2'b00;
			step(3);
			chk_pair(2'b11, 1'b0);
		end
		// zero delay gives no blanking
		wr_reg(4'h1, 16'h0000);
		wr_reg(4'h0, 16'h4c00);
		chin <= 2'b00;
		step(2);
		chk_pair(2'b11, 1'b0);
		chk_pair(2'b11, 1'b0);
		done("edge blanking");
		// unmasked inputs pass through, one low and one high
		cmd <= 2'b10;
		step(5);
		chk_pair(2'b10, 1'b0);
		done("pass through");
		complete_run();
	end
endmodule
`default_nettype wire
